// file: core/swg_pkg.sv
// Package of register indices, field positions and reset values for the
// sleep/wake and pin-level register bank.
// Assumes a single 125 MHz register clock and a word-per-register bus map.
package swg_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0] IDX_NONE      = 8'h00;
  localparam logic [7:0] IDX_WDOG      = 8'hF4;
  localparam logic [7:0] IDX_GRP_ONE   = 8'hF6;
  localparam logic [7:0] IDX_GRP_FIVE  = 8'hF9;
  localparam logic [7:0] IDX_GRP_SIX   = 8'hFA;
  localparam logic [7:0] IDX_SLP_CFG   = 8'hF0;
  localparam logic [7:0] IDX_SLP_CMD   = 8'hE2;
  localparam logic [7:0] IDX_STATUS    = 8'hE3;
  localparam logic [7:0] IDX_MASK      = 8'hE4;
  localparam logic [7:0] IDX_IRQ1_EN   = 8'hE5;
  localparam logic [7:0] IDX_IRQ2_EN5  = 8'hE6;
  localparam logic [7:0] IDX_IRQ2_EN6  = 8'hE7;

  // ==========================================================================
  // Low-index aliases, live only outside configuration mode
  // ==========================================================================
  localparam logic [7:0] ALI_LOW       = 8'h01;
  localparam logic [7:0] ALI_HIGH      = 8'h0F;
  localparam logic [7:0] ALI_GRP_ONE   = 8'h01;
  localparam logic [7:0] ALI_WDOG      = 8'h02;
  localparam logic [7:0] ALI_GRP_FIVE  = 8'h03;
  localparam logic [7:0] ALI_GRP_SIX   = 8'h04;
  localparam logic [7:0] ALI_MASK      = 8'h05;
  localparam logic [7:0] ALI_STATUS    = 8'h06;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CFG_REDIRECT  = 0;
  localparam int CFG_WAKE_SEL  = 1;
  localparam int CFG_PLL_POWER = 7;
  localparam int CTL_SLEEP_EN  = 0;
  localparam int CTL_TYPE_LSB  = 1;
  localparam int TYPE_W        = 3;
  localparam int STS_SLP_SMI   = 0;
  localparam int STS_WAKE      = 1;
  localparam int STS_W         = 2;

  // ==========================================================================
  // Reset values and implemented-bit masks
  // ==========================================================================
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] CFG_MASK      = 8'h83;
  localparam logic [7:0] GRP_FIVE_MASK = 8'h1D;

endpackage : swg_pkg

// file: core/swg_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes the levels may change at any time relative to clk_sys.
`timescale 1ns/100ps
module swg_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } swg_sync_s;

  swg_sync_s s;
  swg_sync_s next_s;

  // The first stage feeds only the second one.
  always_comb begin
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule // swg_sync

// file: core/swg_edge.sv
// Edge detector giving one-cycle rise and fall pulses per input line.
// Assumes the inputs are already synchronous to clk_sys.
`timescale 1ns/100ps
module swg_edge #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Levels and pulses
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } swg_edge_s;

  swg_edge_s s;
  swg_edge_s next_s;

  // Remember the last level so each edge yields a single pulse.
  always_comb begin
    next_s.prev = level;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = level & ~s.prev;
  assign fall = ~level & s.prev;

endmodule // swg_edge

// file: core/swg_regs.sv
// Sleep/wake configuration, pin-level readback and pin interrupt routing,
// reached as an Avalon-MM slave with waitrequest.
// Assumes pins are asynchronous and the bus master runs on clk_sys.
`timescale 1ns/100ps

// Summary of operation
// - Group six pin levels readable at 0xFA
// - Low-index aliases active outside configuration mode
// - Group one to irq one, five/six to two
// - Sleep write starts sleep when not redirected
// - Redirected sleep write raises SMI, no sleep
// - Every sleep write sets SMI status flag
// - Select zero: wake flag on power-on fall
// - Select one: also set on wake events
// - PLL power bit drives infrared PLL
module swg_regs
  import swg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Avalon-MM slave, byte address
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Configuration state from the surrounding controller
  input  wire logic        config_mode,
  // Asynchronous pins
  input  wire logic [7:0]  pin_group_one_lines,
  input  wire logic [7:0]  pin_group_five_lines,
  input  wire logic [7:0]  pin_group_six_lines,
  input  wire logic        power_on_request_n,
  input  wire logic        wake_event,
  input  wire logic        ir_pll_ready,
  // Power sequencer and interrupt outputs
  output logic             sleep_start,
  output logic [2:0]       sleep_type,
  output logic             smi_request,
  output logic             general_irq_one,
  output logic             general_irq_two,
  output logic             ir_pll_power,
  output logic             ir_clk_use_pll,
  output logic             irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic              waitreq;
    logic [7:0]        rdata;
    logic [7:0]        cfg;
    logic [7:0]        wdt;
    logic [7:0]        en_one;
    logic [7:0]        en_five;
    logic [7:0]        en_six;
    logic [STS_W-1:0]  mask;
    logic [STS_W-1:0]  status;
    logic [TYPE_W-1:0] slp_type;
    logic              slp_start;
    logic              smi;
    logic              gpi_one;
    logic              gpi_two;
    logic              pll;
    logic              pll_sel;
    logic              irq;
  } swg_regs_s;

  swg_regs_s s;
  swg_regs_s next_s;

  logic [26:0] pins_sync;
  logic [7:0]  g1_sync;
  logic [7:0]  g5_sync;
  logic [7:0]  g6_sync;
  logic        pwr_n_sync;
  logic        wake_sync;
  logic        pll_ready_sync;
  logic [1:0]  ev_rise;
  logic [1:0]  ev_fall;
  logic        pwr_fall;
  logic        wake_rise;
  logic [7:0]  home;
  logic        req;
  logic        done;
  logic        wr_lo;
  logic        sleep_wr;

  // ==========================================================================
  // Pin synchronisation and edge detection
  // ==========================================================================
  swg_sync #(
    .WIDTH (27)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({ir_pll_ready, wake_event, power_on_request_n,
                pin_group_six_lines, pin_group_five_lines,
                pin_group_one_lines}),
    .sync_out (pins_sync)
  );

  // Levels read by the bank come only from the second stage.
  assign g1_sync        = pins_sync[7:0];
  assign g5_sync        = pins_sync[15:8] & GRP_FIVE_MASK;
  assign g6_sync        = pins_sync[23:16];
  assign pwr_n_sync     = pins_sync[24];
  assign wake_sync      = pins_sync[25];
  assign pll_ready_sync = pins_sync[26];

  swg_edge #(
    .WIDTH (2)
  ) u_edge (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .level   ({wake_sync, pwr_n_sync}),
    .rise    (ev_rise),
    .fall    (ev_fall)
  );

  assign pwr_fall  = ev_fall[0];
  assign wake_rise = ev_rise[1];

  // ==========================================================================
  // Address decoding
  // ==========================================================================
  // Maps a word index to its home index; aliases resolve to the same
  // storage so a read or write through either path has one effect.
  function automatic logic [7:0] map_index(input logic [7:0] w,
                                           input logic       cfg_on);
    logic [7:0] h;
    h = IDX_NONE;
    if (!cfg_on && w >= ALI_LOW && w <= ALI_HIGH) begin
      if (w == ALI_GRP_ONE) begin
        h = IDX_GRP_ONE;
      end else if (w == ALI_WDOG) begin
        h = IDX_WDOG;
      end else if (w == ALI_GRP_FIVE) begin
        h = IDX_GRP_FIVE;
      end else if (w == ALI_GRP_SIX) begin
        h = IDX_GRP_SIX;
      end else if (w == ALI_MASK) begin
        h = IDX_MASK;
      end else if (w == ALI_STATUS) begin
        h = IDX_STATUS;
      end
    end else if (w == IDX_WDOG || w == IDX_GRP_ONE ||
                 w == IDX_GRP_FIVE || w == IDX_GRP_SIX ||
                 w == IDX_SLP_CFG || w == IDX_SLP_CMD ||
                 w == IDX_STATUS || w == IDX_MASK ||
                 w == IDX_IRQ1_EN || w == IDX_IRQ2_EN5 ||
                 w == IDX_IRQ2_EN6) begin
      h = w;
    end
    return h;
  endfunction

  // Read value of a home index; unmapped indices read as zero.
  function automatic logic [7:0] read_value(input logic [7:0] h,
                                            input swg_regs_s  st,
                                            input logic [7:0] g1,
                                            input logic [7:0] g5,
                                            input logic [7:0] g6);
    logic [7:0] v;
    v = 8'h00;
    if (h == IDX_GRP_SIX) begin
      v = g6;
    end else if (h == IDX_GRP_FIVE) begin
      v = g5;
    end else if (h == IDX_GRP_ONE) begin
      v = g1;
    end else if (h == IDX_WDOG) begin
      v = st.wdt;
    end else if (h == IDX_SLP_CFG) begin
      v = st.cfg;
    end else if (h == IDX_SLP_CMD) begin
      v = {4'h0, st.slp_type, 1'b0};
    end else if (h == IDX_STATUS) begin
      v = {6'h00, st.status};
    end else if (h == IDX_MASK) begin
      v = {6'h00, st.mask};
    end else if (h == IDX_IRQ1_EN) begin
      v = st.en_one;
    end else if (h == IDX_IRQ2_EN5) begin
      v = st.en_five;
    end else if (h == IDX_IRQ2_EN6) begin
      v = st.en_six;
    end
    return v;
  endfunction

  assign home     = map_index(avs_address[9:2], config_mode);
  assign req      = avs_read | avs_write;
  // A request completes on the edge where waitrequest is seen low.
  assign done     = req & ~s.waitreq;
  assign wr_lo    = done & avs_write & avs_byteenable[0];
  assign sleep_wr = wr_lo & (home == IDX_SLP_CMD) &
                    avs_writedata[CTL_SLEEP_EN];

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // One wait cycle: sampling a request drops waitrequest with the read
  // data already registered, so the data never lags the handshake.
  always_comb begin
    next_s           = s;
    next_s.slp_start = 1'b0;
    next_s.waitreq   = 1'b1;
    if (req && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata   = avs_read ?
                       read_value(home, s, g1_sync, g5_sync, g6_sync) : 8'h00;
    end

    // Register writes, low byte lane only.
    if (wr_lo) begin
      if (home == IDX_SLP_CFG) begin
        next_s.cfg = avs_writedata[7:0] & CFG_MASK;
      end else if (home == IDX_WDOG) begin
        next_s.wdt = avs_writedata[7:0];
      end else if (home == IDX_SLP_CMD) begin
        next_s.slp_type = avs_writedata[CTL_TYPE_LSB +: TYPE_W];
      end else if (home == IDX_MASK) begin
        next_s.mask = avs_writedata[STS_W-1:0];
      end else if (home == IDX_IRQ1_EN) begin
        next_s.en_one = avs_writedata[7:0];
      end else if (home == IDX_IRQ2_EN5) begin
        next_s.en_five = avs_writedata[7:0] & GRP_FIVE_MASK;
      end else if (home == IDX_IRQ2_EN6) begin
        next_s.en_six = avs_writedata[7:0];
      end
    end

    // Status read clears first, so a same-cycle event below still sets.
    if (done && avs_read && home == IDX_STATUS) begin
      next_s.status = '0;
    end

    // Sleep-enable writes: start only when not redirected.
    if (sleep_wr) begin
      next_s.status[STS_SLP_SMI] = 1'b1;
      if (!s.cfg[CFG_REDIRECT]) begin
        next_s.slp_start = 1'b1;
        next_s.slp_type  = avs_writedata[CTL_TYPE_LSB +: TYPE_W];
      end
    end

    // Wake status sources chosen by the select bit.
    if (pwr_fall) begin
      next_s.status[STS_WAKE] = 1'b1;
    end
    if (s.cfg[CFG_WAKE_SEL] && wake_rise) begin
      next_s.status[STS_WAKE] = 1'b1;
    end

    // The flag always sets; only the redirect lets it reach the SMI.
    next_s.smi = next_s.status[STS_SLP_SMI] &
                 next_s.cfg[CFG_REDIRECT];
    next_s.gpi_one = |(g1_sync & s.en_one);
    next_s.gpi_two = |(g5_sync & s.en_five) |
                     |(g6_sync & s.en_six);
    // The clock switch waits for the PLL to report ready, so the wake
    // detector never runs from an unsettled clock.
    next_s.pll     = s.cfg[CFG_PLL_POWER];
    next_s.pll_sel = s.cfg[CFG_PLL_POWER] & pll_ready_sync;
    next_s.irq     = |(next_s.status & next_s.mask);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s         <= '0;
      s.waitreq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata    = {24'h000000, s.rdata};
  assign avs_waitrequest = s.waitreq;
  assign sleep_start     = s.slp_start;
  assign sleep_type      = s.slp_type;
  assign smi_request     = s.smi;
  assign general_irq_one = s.gpi_one;
  assign general_irq_two = s.gpi_two;
  assign ir_pll_power    = s.pll;
  assign ir_clk_use_pll  = s.pll_sel;
  assign irq             = s.irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  grp_six_read_a: assert property (
    (avs_read && s.waitreq && avs_address[9:2] == IDX_GRP_SIX)
    |=> (!avs_waitrequest && avs_readdata[7:0] == $past(g6_sync)))
    else $error("group six read value wrong");

  alias_read_a: assert property (
    (avs_read && s.waitreq && !config_mode &&
     avs_address[9:2] == ALI_GRP_SIX)
    |=> (avs_readdata == {24'h000000, $past(g6_sync)}))
    else $error("alias read value wrong");

  irq_one_route_a: assert property (
    ((g1_sync & s.en_one) != 8'h00) |=> general_irq_one)
    else $error("group one line not routed");

  sleep_start_a: assert property (
    (sleep_wr && !s.cfg[CFG_REDIRECT])
    |=> (sleep_start && !smi_request) ##1 !sleep_start)
    else $error("sleep start pulse wrong");

  redirect_smi_a: assert property (
    (sleep_wr && s.cfg[CFG_REDIRECT] && !wr_lo_cfg_change())
    |=> (!sleep_start && smi_request))
    else $error("redirect did not raise smi");

  smi_flag_a: assert property (
    sleep_wr |=> s.status[STS_SLP_SMI])
    else $error("sleep smi flag not set");

  wake_sel_zero_a: assert property (
    (wake_rise && !pwr_fall && !s.cfg[CFG_WAKE_SEL] &&
     !s.status[STS_WAKE]) |=> !s.status[STS_WAKE])
    else $error("wake flag set by masked source");

  wake_power_on_a: assert property (
    (pwr_fall || (wake_rise && s.cfg[CFG_WAKE_SEL]))
    |=> s.status[STS_WAKE])
    else $error("wake flag not set");

  pll_power_a: assert property (
    !s.cfg[CFG_PLL_POWER] |=> (!ir_pll_power && !ir_clk_use_pll))
    else $error("pll powered while off");

  single_pulse_a: assert property (
    pwr_fall |=> !pwr_fall)
    else $error("power-on edge not single");

  // True when the current write also rewrites the configuration register.
  function automatic logic wr_lo_cfg_change();
    return wr_lo && home == IDX_SLP_CFG;
  endfunction

endmodule // swg_regs

// file: bench/swg_pin_model.sv
// Far-side model: pin groups, power-on request, wake line and PLL ready.
// Assumes its tasks are called just after a rising edge of clk_sys.
`timescale 1ns/100ps
// ============================================================================
// Pin and power-sequencer model
// ============================================================================
module swg_pin_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Sequencer command from the register bank
  input  wire logic sleep_start,
  // Pins towards the register bank
  output logic [7:0] pin_group_one_lines,
  output logic [7:0] pin_group_five_lines,
  output logic [7:0] pin_group_six_lines,
  output logic       power_on_request_n,
  output logic       wake_event,
  output logic       ir_pll_ready,
  // Count of sleep entries seen by the sequencer
  output logic [7:0] sleep_pulses
);
  // The request line rests high; every other pin rests low.
  initial begin
    pin_group_one_lines  = 8'h00;
    pin_group_five_lines = 8'h00;
    pin_group_six_lines  = 8'h00;
    power_on_request_n   = 1'b1;
    wake_event           = 1'b0;
    ir_pll_ready         = 1'b0;
  end

  // Counting high cycles, not rising edges, shows a stretched command at once.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sleep_pulses <= 8'h00;
    end else if (sleep_start === 1'b1) begin
      sleep_pulses <= sleep_pulses + 8'h01;
    end
  end

  // Pin group levels change together, as a real port would.
  task automatic set_pins(input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] c);
    pin_group_one_lines  <= a;
    pin_group_five_lines <= b;
    pin_group_six_lines  <= c;
  endtask

  // Single control lines; the bench chooses when edges occur.
  task automatic set_ctl(input logic p, input logic w, input logic r);
    power_on_request_n <= p;
    wake_event         <= w;
    ir_pll_ready       <= r;
  endtask
endmodule // swg_pin_model

// file: bench/test_swg_regs.sv
// Self-checking bench for the sleep/wake register bank.
// Assumes swg_pkg and the design files are compiled before this file.
`timescale 1ns/100ps
module test_swg_regs;
  import swg_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_sys        = 1'b0;
  logic        sys_rst        = 1'b1;
  logic [9:0]  avs_address    = 10'h000;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_writedata  = 32'h00000000;
  logic        config_mode    = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pin_group_one_lines, pin_group_five_lines, pin_group_six_lines;
  logic        power_on_request_n, wake_event, ir_pll_ready;
  logic        sleep_start, smi_request, general_irq_one, general_irq_two;
  logic        ir_pll_power, ir_clk_use_pll, irq;
  logic [2:0]  sleep_type;
  logic [7:0]  sleep_pulses;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #4 clk_sys = ~clk_sys;

  swg_regs dut (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .config_mode, .pin_group_one_lines, .pin_group_five_lines,
    .pin_group_six_lines, .power_on_request_n, .wake_event, .ir_pll_ready,
    .sleep_start, .sleep_type, .smi_request, .general_irq_one,
    .general_irq_two, .ir_pll_power, .ir_clk_use_pll, .irq);

  swg_pin_model pm (.clk_sys, .sys_rst, .sleep_start, .pin_group_one_lines,
    .pin_group_five_lines, .pin_group_six_lines, .power_on_request_n,
    .wake_event, .ir_pll_ready, .sleep_pulses);

  // ==========================================================================
  // Closing report and hang guard
  // ==========================================================================
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  // ==========================================================================
  // Bus access and compare tasks
  // ==========================================================================
  task automatic chk_byte(input string nm, input logic [7:0] g,
                          input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  // One access; the request holds until waitrequest is sampled low.
  task automatic acc(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx,
                        input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, idx, 8'h00, q);
    chk_byte(nm, q, e);
  endtask

  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk("cfg_reset", IDX_SLP_CFG, 8'h00);
    rd_chk("six_reset", IDX_GRP_SIX, 8'h00);
    chk_bit("irq_reset", irq, 1'b0);
    // Only the three documented configuration bits hold a value.
    wr(IDX_SLP_CFG, 8'hFF);
    rd_chk("cfg_bits", IDX_SLP_CFG, 8'h83);
    wr(IDX_SLP_CFG, 8'h80);
    settle();
    chk_bit("pll_power", ir_pll_power, 1'b1);
    chk_bit("pll_not_ready", ir_clk_use_pll, 1'b0);
    pm.set_ctl(1'b1, 1'b0, 1'b1);
    settle();
    chk_bit("pll_in_use", ir_clk_use_pll, 1'b1);
    wr(IDX_SLP_CFG, 8'h00);
    settle();
    chk_bit("pll_off", ir_pll_power, 1'b0);
    chk_bit("pll_unused", ir_clk_use_pll, 1'b0);
    // Pin readback, read-only behaviour and the low aliases.
    pm.set_pins(8'h81, 8'hFF, 8'hA5);
    settle();
    rd_chk("six_level", IDX_GRP_SIX, 8'hA5);
    wr(IDX_GRP_SIX, 8'h00);
    rd_chk("six_readonly", IDX_GRP_SIX, 8'hA5);
    rd_chk("one_alias", ALI_GRP_ONE, 8'h81);
    rd_chk("five_alias", ALI_GRP_FIVE, 8'h1D);
    rd_chk("six_alias", ALI_GRP_SIX, 8'hA5);
    wr(ALI_WDOG, 8'h5A);
    rd_chk("wdt_alias", IDX_WDOG, 8'h5A);
    config_mode <= 1'b1;
    rd_chk("alias_off", ALI_GRP_SIX, 8'h00);
    config_mode <= 1'b0;
    rd_chk("unmapped", 8'h10, 8'h00);
    // Interrupt routing of the pin groups.
    chk_bit("irq1_disabled", general_irq_one, 1'b0);
    wr(IDX_IRQ1_EN, 8'h80);
    wr(IDX_IRQ2_EN6, 8'h04);
    settle();
    chk_bit("irq1_on", general_irq_one, 1'b1);
    chk_bit("irq2_six", general_irq_two, 1'b1);
    pm.set_pins(8'h01, 8'h00, 8'hA1);
    settle();
    chk_bit("irq1_low", general_irq_one, 1'b0);
    chk_bit("irq2_low", general_irq_two, 1'b0);
    wr(IDX_IRQ2_EN5, 8'h01);
    pm.set_pins(8'h01, 8'h01, 8'hA1);
    settle();
    chk_bit("irq2_five", general_irq_two, 1'b1);
    // Sleep write without redirect: one sleep entry of type three.
    wr(IDX_SLP_CMD, 8'h07);
    settle();
    chk_byte("sleep_count", sleep_pulses, 8'h01);
    chk_byte("sleep_type", {5'h00, sleep_type}, 8'h03);
    chk_bit("smi_quiet", smi_request, 1'b0);
    rd_chk("smi_flag", IDX_STATUS, 8'h01);
    rd_chk("sts_cleared", IDX_STATUS, 8'h00);
    // Redirected sleep write raises the SMI and sleeps not.
    wr(IDX_SLP_CFG, 8'h01);
    wr(IDX_SLP_CMD, 8'h01);
    settle();
    chk_byte("no_sleep", sleep_pulses, 8'h01);
    chk_bit("smi_raised", smi_request, 1'b1);
    rd_chk("smi_flag_alias", ALI_STATUS, 8'h01);
    settle();
    chk_bit("smi_cleared", smi_request, 1'b0);
    // Select zero: wake line ignored, request fall sets the flag once.
    wr(IDX_SLP_CFG, 8'h00);
    pm.set_ctl(1'b1, 1'b1, 1'b1);
    settle();
    rd_chk("wake_ignored", IDX_STATUS, 8'h00);
    wr(IDX_MASK, 8'h02);
    pm.set_ctl(1'b0, 1'b0, 1'b1);
    settle();
    chk_bit("irq_set", irq, 1'b1);
    rd_chk("wake_by_power", IDX_STATUS, 8'h02);
    rd_chk("wake_once", IDX_STATUS, 8'h00);
    chk_bit("irq_cleared", irq, 1'b0);
    // Select one: enabled wake events and request falls both count.
    wr(IDX_SLP_CFG, 8'h02);
    pm.set_ctl(1'b1, 1'b1, 1'b1);
    settle();
    rd_chk("wake_by_event", IDX_STATUS, 8'h02);
    rd_chk("event_once", IDX_STATUS, 8'h00);
    wr(ALI_MASK, 8'h00);
    pm.set_ctl(1'b0, 1'b1, 1'b1);
    settle();
    chk_bit("irq_masked", irq, 1'b0);
    rd_chk("wake_by_power_sel1", IDX_STATUS, 8'h02);
    end_sim();
  end
endmodule // test_swg_regs
